/* File: rtl/data_fragment_submessage_checker.v */
// checks data and fragment submessages and tracks fragment reassembly
//
// How it works
// - data flag alone: payload is value
// - key flag alone: payload is key
// - inline qos overrides writer qos
// - non-standard payload flag only informational
// - writer guid = source prefix, writer id
// - reader guid = dest prefix, reader id
// - unknown reader id: all readers of writer
// - starting fragment index counts from one
// - payload holds consecutive run of fragments
// - data size is the reassembly target
// - fragment size at most 64K bytes
// - inline qos present only when flagged
// - fragment key flag picks value or key
// - too short submessage is invalid
// - sequence number below one or unknown invalid
// - starting fragment out of range invalid
// - fragment size or payload too large invalid
// - segment offset is (start minus one) times size
// - fragment count is size ratio rounded up
// - complete only when all fragments received
`include "data_fragment_submessage_checker_defines.vh"

module data_fragment_submessage_checker #(
    parameter MAX_FRAGS = 64
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_we,
    input wire reg_re,
    output reg [31:0] reg_rdata,
    // receiver state
    input wire [95:0] source_prefix,
    input wire [95:0] dest_prefix,
    // parsed submessage
    input wire sub_valid,
    input wire sub_is_frag,
    input wire flag_inline_qos,
    input wire flag_data,
    input wire flag_key,
    input wire flag_nonstd,
    input wire [15:0] sub_len,
    input wire [31:0] reader_id,
    input wire [31:0] writer_id,
    input wire [31:0] writer_sn_hi,
    input wire [31:0] writer_sn_lo,
    input wire [15:0] qos_len,
    input wire qos_ok,
    input wire [15:0] payload_len,
    input wire [31:0] frag_start,
    input wire [15:0] frags_in_sub,
    input wire [31:0] data_size,
    input wire [15:0] frag_size,
    // checked result
    output reg res_valid,
    output reg res_invalid,
    output reg res_is_frag,
    output reg [127:0] writer_guid,
    output reg [127:0] reader_guid,
    output reg reader_all,
    output reg payload_is_value,
    output reg payload_is_key,
    output reg qos_override,
    output reg payload_nonstd,
    output reg [47:0] frag_offset,
    output reg [31:0] frag_total,
    output reg [31:0] target_size,
    output reg reassembly_done
);

    ////////////////////////////////////////////////////////////////////////////
    // validity checks

    reg [31:0] ctrl_q;
    reg [`RSN_WIDTH-1:0] last_reason_q;
    reg [31:0] accept_cnt_q;
    reg [31:0] invalid_cnt_q;
    reg [31:0] complete_cnt_q;
    reg track_active_q;
    reg [127:0] track_guid_q;
    reg [63:0] track_sn_q;
    reg [31:0] track_total_q;
    reg [MAX_FRAGS-1:0] track_map_q;

    wire enable = ctrl_q[`CTRL_ENABLE_BIT];
    wire take = sub_valid & enable;
    wire [127:0] wguid = {source_prefix, writer_id};
    wire [63:0] sn = {writer_sn_hi, writer_sn_lo};

    // qos bytes only counted when flagged
    // 18 bits so three 16-bit terms never wrap
    wire [17:0] need_len = {2'b00, (sub_is_frag ? `FRAG_FIXED_LEN : `DATA_FIXED_LEN)}
        + {2'b00, (flag_inline_qos ? qos_len : 16'h0000)}
        + {2'b00, payload_len};
    wire bad_len = {2'b00, sub_len} < need_len;

    // sequence number positive and known
    // the unknown marker is negative too; tested apart for clarity
    wire sn_unknown = (writer_sn_hi == `SN_UNKNOWN_HI) && (writer_sn_lo == `SN_UNKNOWN_LO);
    wire bad_sn = writer_sn_hi[31] | (sn == 64'h0) | sn_unknown;

    wire [32:0] total_w = (frag_size == 16'h0000) ? 33'h0 :
        (({1'b0, data_size} + {17'h0, frag_size} - 33'h1) / {17'h0, frag_size});
    // zero-based index of the first fragment
    wire [31:0] start_m1 = frag_start - 32'h1;
    // 48 bits hold the largest index times the largest size
    wire [47:0] offset_w = {16'h0000, start_m1} * {32'h0000_0000, frag_size};

    wire bad_start = (frag_start == 32'h0) | ({1'b0, frag_start} > total_w);
    // zero size would make every count meaningless, so it fails too
    // size field cannot exceed 64K by width
    wire bad_fsize = (frag_size == 16'h0000) | ({16'h0, frag_size} > data_size);
    // payload must fit the announced run
    // a 16 by 16 product always fits 32 bits
    wire [31:0] run_bytes = {16'h0000, frags_in_sub} * {16'h0000, frag_size};
    wire bad_payload = {16'h0, payload_len} > run_bytes;
    wire bad_qos = flag_inline_qos & ~qos_ok;
    // bitmap covers MAX_FRAGS; larger samples are refused, not truncated
    wire [32:0] frag_cap = {1'b0, MAX_FRAGS[31:0]};
    wire bad_cap = total_w > frag_cap;

    wire [`RSN_WIDTH-1:0] reason = {
        sub_is_frag & bad_cap,
        bad_qos,
        sub_is_frag & bad_payload,
        sub_is_frag & bad_fsize,
        sub_is_frag & bad_start,
        bad_sn,
        bad_len};
    wire invalid = |reason;

    ////////////////////////////////////////////////////////////////////////////
    // fragment bitmap

    // 33-bit compare so a run ending at the top index cannot wrap
    function in_run;
        input [31:0] idx;
        input [31:0] first;
        input [15:0] count;
        begin
            in_run = ({1'b0, idx} >= {1'b0, first})
                && ({1'b0, idx} < ({1'b0, first} + {17'h0, count}));
        end
    endfunction

    // same sample continues the map, anything else restarts it
    wire same_sample = track_active_q && (track_guid_q == wguid) && (track_sn_q == sn);
    wire frag_take = take & sub_is_frag & ~invalid;

    wire [MAX_FRAGS-1:0] run_mask;
    wire [MAX_FRAGS-1:0] need_mask;
    genvar gi;
    generate
        for (gi = 0; gi < MAX_FRAGS; gi = gi + 1) begin : g_map
            // bit zero holds fragment number one
            assign run_mask[gi] = in_run(gi + 1, frag_start, frags_in_sub);
            assign need_mask[gi] = ({1'b0, 32'd0 + gi} < total_w);
        end
    endgenerate

    // earlier bits count only while the same sample continues
    wire [MAX_FRAGS-1:0] map_d = (same_sample ? track_map_q : {MAX_FRAGS{1'b0}}) | run_mask;
    // every expected bit must be set
    wire all_rcvd = &(map_d | ~need_mask);

    ////////////////////////////////////////////////////////////////////////////
    // result and tracking state

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_invalid <= 1'b0;
            res_is_frag <= 1'b0;
            writer_guid <= 128'h0;
            reader_guid <= 128'h0;
            reader_all <= 1'b0;
            payload_is_value <= 1'b0;
            payload_is_key <= 1'b0;
            qos_override <= 1'b0;
            payload_nonstd <= 1'b0;
            frag_offset <= 48'h0;
            frag_total <= 32'h0;
            target_size <= 32'h0;
            reassembly_done <= 1'b0;
            track_active_q <= 1'b0;
            track_guid_q <= 128'h0;
            track_sn_q <= 64'h0;
            track_total_q <= 32'h0;
            track_map_q <= {MAX_FRAGS{1'b0}};
        end else begin
            res_valid <= take & ~invalid;
            res_invalid <= take & invalid;
            reassembly_done <= 1'b0;
            if (take) begin
                res_is_frag <= sub_is_frag;
                writer_guid <= wguid;
                reader_guid <= {dest_prefix, reader_id};
                // broadcast to all readers of the writer
                reader_all <= (reader_id == `ENTITY_UNKNOWN);
                // value payload; fragments of value without key flag
                payload_is_value <= sub_is_frag ? ~flag_key : (flag_data & ~flag_key);
                // key payload; fragments of key with key flag
                payload_is_key <= sub_is_frag ? flag_key : (flag_key & ~flag_data);
                // inline values win over the writer defaults
                qos_override <= flag_inline_qos;
                // carried along only, no effect on checks
                payload_nonstd <= flag_nonstd;
                frag_offset <= sub_is_frag ? offset_w : 48'h0;
                frag_total <= sub_is_frag ? total_w[31:0] : 32'h0;
                target_size <= sub_is_frag ? data_size : {16'h0, payload_len};
            end
            // flush wins over a fragment in the same cycle
            if (ctrl_q[`CTRL_FLUSH_BIT]) begin
                track_active_q <= 1'b0;
                track_map_q <= {MAX_FRAGS{1'b0}};
            // invalid ones never reach the map
            end else if (frag_take) begin
                // later fragments without qos still continue the sample
                track_guid_q <= wguid;
                track_sn_q <= sn;
                track_total_q <= total_w[31:0];
                // done pulse, and the map is freed in the same cycle
                if (all_rcvd) begin
                    reassembly_done <= 1'b1;
                    track_active_q <= 1'b0;
                    track_map_q <= {MAX_FRAGS{1'b0}};
                end else begin
                    track_active_q <= 1'b1;
                    track_map_q <= map_d;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CTRL_RESET_VAL;
            last_reason_q <= {`RSN_WIDTH{1'b0}};
            accept_cnt_q <= 32'h0;
            invalid_cnt_q <= 32'h0;
            complete_cnt_q <= 32'h0;
        end else begin
            // flush is a self-clearing command bit
            ctrl_q[`CTRL_FLUSH_BIT] <= 1'b0;
            // a write in the same cycle overrides the self-clear
            if (reg_we && reg_addr == `ADDR_CTRL) begin
                ctrl_q <= reg_wdata & 32'h0000_0003;
            end
            // counters wrap; software compares successive readings
            if (take & ~invalid) begin
                accept_cnt_q <= accept_cnt_q + 32'h1;
            end
            if (take & invalid) begin
                invalid_cnt_q <= invalid_cnt_q + 32'h1;
                last_reason_q <= reason;
            end
            if (reassembly_done) begin
                complete_cnt_q <= complete_cnt_q + 32'h1;
            end
        end
    end

    // read data only in the cycle after the strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_re) begin
            case (reg_addr)
                `ADDR_CTRL: reg_rdata <= ctrl_q;
                `ADDR_STATUS: reg_rdata <= {31'h0, track_active_q};
                `ADDR_ACCEPT_CNT: reg_rdata <= accept_cnt_q;
                `ADDR_INVALID_CNT: reg_rdata <= invalid_cnt_q;
                `ADDR_COMPLETE_CNT: reg_rdata <= complete_cnt_q;
                `ADDR_FRAG_TOTAL: reg_rdata <= track_total_q;
                `ADDR_LAST_REASON: reg_rdata <= {25'h0, last_reason_q};
                // unmapped words read as zero
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule // data_fragment_submessage_checker

/* File: shared/data_fragment_submessage_checker_defines.vh */
// constants for the data and fragment submessage checker
`ifndef DATA_FRAGMENT_SUBMESSAGE_CHECKER_DEFINES_VH
`define DATA_FRAGMENT_SUBMESSAGE_CHECKER_DEFINES_VH

// register word addresses
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_ACCEPT_CNT 4'h2
`define ADDR_INVALID_CNT 4'h3
`define ADDR_COMPLETE_CNT 4'h4
`define ADDR_FRAG_TOTAL 4'h5
`define ADDR_LAST_REASON 4'h6

// control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_FLUSH_BIT 1
`define CTRL_RESET_VAL 32'h0000_0001

// reason fields
`define RSN_LENGTH 0
`define RSN_SEQNUM 1
`define RSN_START 2
`define RSN_FSIZE 3
`define RSN_PAYLOAD 4
`define RSN_QOS 5
`define RSN_CAPACITY 6
`define RSN_WIDTH 7

// fixed element bytes after the submessage header
`define DATA_FIXED_LEN 16'h0014
`define FRAG_FIXED_LEN 16'h0020

// sequence number marker for unknown
`define SN_UNKNOWN_HI 32'hFFFF_FFFF
`define SN_UNKNOWN_LO 32'h0000_0000

// entity id meaning any reader
`define ENTITY_UNKNOWN 32'h0000_0000

`endif

/* File: tb/data_fragment_submessage_checker_properties.sv */
// assertions for the data and fragment submessage checker
module dfsc_props (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // register port
    input logic [3:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_we,
    // submessage
    input logic sub_valid,
    input logic sub_is_frag,
    input logic [15:0] sub_len,
    input logic [31:0] writer_sn_hi,
    input logic [31:0] writer_sn_lo,
    input logic [95:0] source_prefix,
    input logic [31:0] writer_id,
    input logic [31:0] reader_id,
    input logic [31:0] frag_start,
    input logic [31:0] data_size,
    input logic [15:0] frag_size,
    // results
    input logic res_valid,
    input logic res_invalid,
    input logic [127:0] writer_guid,
    input logic reader_all,
    input logic [47:0] frag_offset,
    input logic reassembly_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_q;
    wire taken = sub_valid && en_q;
    // shadow of the enable bit, since it gates acceptance
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) en_q <= 1'b1;
        else if (reg_we && reg_addr == 4'h0) en_q <= reg_wdata[0];
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    property p_one_answer; taken |=> res_valid != res_invalid; endproperty
    a_one_answer: assert property (p_one_answer) else $error("no single answer");
    property p_quiet; !taken |=> !res_valid && !res_invalid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_wguid; taken |=> writer_guid == {$past(source_prefix), $past(writer_id)}; endproperty
    a_wguid: assert property (p_wguid) else $error("writer guid wrong");
    property p_all; taken |=> reader_all == ($past(reader_id) == 32'h0); endproperty
    a_all: assert property (p_all) else $error("reader all wrong");
    property p_sn;
        taken && (writer_sn_hi[31] || {writer_sn_hi, writer_sn_lo} == 64'h0
            || {writer_sn_hi, writer_sn_lo} == 64'hFFFF_FFFF_0000_0000) |=> res_invalid;
    endproperty
    a_sn: assert property (p_sn) else $error("bad sequence accepted");
    property p_len; taken && !sub_is_frag && sub_len < 16'h0014 |=> res_invalid; endproperty
    a_len: assert property (p_len) else $error("short data accepted");
    property p_start; taken && sub_is_frag && frag_start == 32'h0 |=> res_invalid; endproperty
    a_start: assert property (p_start) else $error("start zero accepted");
    property p_fsize; taken && sub_is_frag && {16'h0, frag_size} > data_size |=> res_invalid;
    endproperty
    a_fsize: assert property (p_fsize) else $error("fragment size accepted");
    property p_offset;
        taken && sub_is_frag |=> !res_valid
            || frag_offset == ({16'h0, $past(frag_start)} - 48'h1) * {32'h0, $past(frag_size)};
    endproperty
    a_offset: assert property (p_offset) else $error("offset wrong");
    property p_done; reassembly_done |-> res_valid; endproperty
    a_done: assert property (p_done) else $error("done without accept");
    c_done: cover property (res_valid && reassembly_done);
    c_bad: cover property (res_invalid);
    c_off: cover property (sub_valid && !en_q);
endmodule // dfsc_props

bind data_fragment_submessage_checker dfsc_props u_props (.*);

/* File: tb/data_fragment_submessage_checker_tb.sv */
// self-checking bench for the data and fragment submessage checker
module data_fragment_submessage_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic f;
        logic [31:0] st;
        logic [15:0] n, sz;
        logic [31:0] tot, hi, lo;
        logic [2:0] fl;
        logic [1:0] ft;
        logic inv;
        logic [31:0] et;
        logic dn;
    } row_t;
    logic core_clk, rst_n, reg_we, reg_re, send, sub_valid, sub_is_frag, qos_ok;
    logic flag_inline_qos, flag_data, flag_key, flag_nonstd;
    logic res_valid, res_invalid, res_is_frag, reader_all, reassembly_done;
    logic payload_is_value, payload_is_key, qos_override, payload_nonstd;
    logic [1:0] fault;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, reader_id, writer_sn_hi, writer_sn_lo;
    logic [31:0] writer_id = 32'h0000_0102;
    logic [31:0] frag_start, data_size, frag_total, target_size;
    logic [15:0] sub_len, qos_len, payload_len, frags_in_sub, frag_size;
    logic [95:0] source_prefix = 96'h0A0B_0C0D_0E0F_1011_1213_1415;
    logic [95:0] dest_prefix = 96'h5A5B_5C5D_5E5F_6061_6263_6465;
    logic [127:0] writer_guid, reader_guid;
    logic [47:0] frag_offset;
    int n_fail, n_compared, cyc;
    row_t r;
    // f st n sz tot hi lo flags fault invalid total done
    row_t rows[14] = '{
        '{1, 1, 2, 100, 200, 0, 1, 3'h4, 0, 0, 2, 1}, '{1, 1, 1, 100, 250, 0, 2, 3'h2, 0, 0, 3, 0},
        '{1, 0, 1, 100, 250, 0, 2, 3'h0, 0, 1, 0, 0}, '{1, 2, 2, 100, 250, 0, 2, 3'h1, 0, 0, 3, 1},
        '{1, 4, 1, 100, 250, 0, 3, 3'h0, 0, 1, 0, 0}, '{1, 1, 1, 300, 250, 0, 3, 3'h0, 0, 1, 0, 0},
        '{1, 1, 1, 10, 100, 0, 3, 3'h0, 0, 1, 0, 0}, '{1, 1, 1, 100, 250, 0, 3, 3'h0, 1, 1, 0, 0},
        '{0, 1, 1, 40, 40, 0, 0, 3'h4, 0, 1, 0, 0}, '{0, 1, 1, 40, 40, '1, 0, 3'h4, 0, 1, 0, 0},
        '{0, 1, 1, 40, 40, 32'h8000_0000, 5, 3'h4, 0, 1, 0, 0},
        '{0, 1, 1, 40, 40, 0, 5, 3'h4, 2, 1, 0, 0}, '{0, 1, 1, 40, 40, 0, 6, 3'h4, 0, 0, 0, 0},
        '{0, 1, 1, 40, 40, 0, 7, 3'h2, 0, 0, 0, 0}};

    data_fragment_submessage_checker #(.MAX_FRAGS(8)) dut (.*);
    dfsc_writer u_writer (.*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // frame one row, results stand two edges after the request
    task put(input int i);
        r = rows[i];
        @(posedge core_clk);
        {sub_is_frag, frag_start, frags_in_sub, frag_size, data_size} <= {r.f, r.st, r.n, r.sz, r.tot};
        {writer_sn_hi, writer_sn_lo, flag_data, flag_key, flag_nonstd} <= {r.hi, r.lo, r.fl};
        reader_id <= i[0] ? 32'h0 : 32'h0000_0103;
        fault <= r.ft;
        send <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_we, reg_re, send, fault, reg_addr, reg_wdata, reader_id} = '0;
        {sub_is_frag, frag_start, frags_in_sub, frag_size, data_size} = '0;
        {writer_sn_hi, writer_sn_lo, flag_data, flag_key, flag_nonstd} = '0;
        qos_ok = 1'b1;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(4'h0, 32'h1);
        @(posedge core_clk);
        #1 chk(reg_rdata, 32'h0);
        rd(4'h2, 32'h0);
        wr(4'h7, 32'hFFFF_FFFF);
        rd(4'h7, 32'h0);
        for (int i = 0; i < 14; i++) begin
            put(i);
            chk(res_valid, !r.inv);
            chk(res_invalid, r.inv);
            chk(res_is_frag, r.f);
            if (!r.inv) begin
                chk(writer_guid, {source_prefix, writer_id});
                chk(reader_guid, {dest_prefix, reader_id});
                chk(reader_all, reader_id == 32'h0);
                chk(payload_is_key, r.f ? r.fl[1] : r.fl[1] & !r.fl[2]);
                chk(payload_is_value, r.f ? !r.fl[1] : r.fl[2] & !r.fl[1]);
                chk(payload_nonstd, r.fl[0]);
                chk(qos_override, r.st == 32'h1);
                chk(frag_offset, r.f ? {16'h0, r.st - 32'h1} * r.sz : 0);
                chk(frag_total, r.et);
                chk(target_size, r.f ? r.tot : r.n * r.sz);
                chk(reassembly_done, r.dn);
            end
        end
        rd(4'h2, 32'h5);
        rd(4'h3, 32'h9);
        rd(4'h4, 32'h2);
        rd(4'h6, 32'h1);
        wr(4'h0, 32'h0);
        put(0);
        chk(res_valid | res_invalid, 1'b0);
        wr(4'h0, 32'h1);
        rd(4'h2, 32'h5);
        put(1);
        rd(4'h1, 32'h1);
        rd(4'h5, 32'h3);
        @(posedge core_clk);
        qos_ok <= 1'b0;
        put(1);
        chk(res_invalid, 1'b1);
        rd(4'h6, 32'h20);
        rd(4'h1, 32'h1);
        @(posedge core_clk);
        qos_ok <= 1'b1;
        wr(4'h0, 32'h3);
        rd(4'h1, 32'h0);
        put(3);
        chk(reassembly_done, 1'b0);
        put(1);
        chk(reassembly_done, 1'b1);
        put(1);
        put(0);
        chk(reassembly_done, 1'b1);
        put(3);
        chk(reassembly_done, 1'b0);
        rd(4'h2, 32'hB);
        rd(4'h3, 32'hA);
        rd(4'h4, 32'h4);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk(writer_guid, 128'h0);
        rd(4'h4, 32'h0);
        rd(4'h0, 32'h1);
        finish_test();
    end
endmodule // data_fragment_submessage_checker_tb

/* File: tb/dfsc_writer.sv */
// remote writer model framing data and fragment submessages
module dfsc_writer (
    // clock and request
    input logic core_clk,
    input logic send,
    input logic [1:0] fault,
    input logic sub_is_frag,
    input logic [31:0] frag_start,
    input logic [15:0] frags_in_sub,
    input logic [15:0] frag_size,
    input logic [31:0] data_size,
    // submessage out
    output logic sub_valid,
    output logic flag_inline_qos,
    output logic [15:0] qos_len,
    output logic [15:0] payload_len,
    output logic [15:0] sub_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] run, left;
    logic [15:0] pay, qlen;
    assign run = frags_in_sub * frag_size;
    assign left = data_size - (frag_start - 32'h1) * frag_size;
    assign pay = (run < left) ? run[15:0] : left[15:0];
    // qos only with the first fragment
    assign qlen = (frag_start == 32'h1) ? 16'h0008 : 16'h0000;
    // fault bits break payload or length on command
    always @(posedge core_clk) begin
        sub_valid <= send;
        flag_inline_qos <= frag_start == 32'h1;
        qos_len <= qlen;
        payload_len <= pay + {15'h0, fault[0]};
        sub_len <= (sub_is_frag ? 16'h0020 : 16'h0014) + qlen + pay + {15'h0, fault[0]}
            - {15'h0, fault[1]};
    end
endmodule // dfsc_writer
